/* File: src/dea_defines.vh */
// register map, field positions, reset values, source codes and frame length for the dual event alarm unit
`ifndef DEA_DEFINES_VH
`define DEA_DEFINES_VH

// ==========================================================
// register word addresses (even byte of each pair)
`define DEA_ADR_FLASH_COUNT 7'h00
`define DEA_ADR_THR1 7'h20
`define DEA_ADR_THR2 7'h22
`define DEA_ADR_SMPL1 7'h24
`define DEA_ADR_SMPL2 7'h26
`define DEA_ADR_CONFIG 7'h28
`define DEA_ADR_STATUS 7'h3C

// ==========================================================
// reset values
`define DEA_RST_THR 16'h0000
`define DEA_RST_SMPL 16'h0000
`define DEA_RST_CONFIG 16'h0000
`define DEA_RST_STATUS 2'h0

// ==========================================================
// threshold and sample count fields
`define DEA_THR_DIR 15
`define DEA_THR_MAG_HI 13
`define DEA_THR_MAG_LO 0
`define DEA_SMPL_HI 7

// ==========================================================
// config fields
`define DEA_CFG_SLOPE2 15
`define DEA_CFG_SRC2_HI 14
`define DEA_CFG_SRC2_LO 12
`define DEA_CFG_SLOPE1 11
`define DEA_CFG_SRC1_HI 10
`define DEA_CFG_SRC1_LO 8
`define DEA_CFG_FILT 4
`define DEA_CFG_OUT_EN 2
`define DEA_CFG_OUT_POL 1
`define DEA_CFG_OUT_SEL 0

// ==========================================================
// source codes
`define DEA_SRC_SUPPLY 3'h1
`define DEA_SRC_GYRO 3'h2
`define DEA_SRC_AUX 3'h5
`define DEA_SRC_TEMP 3'h6

// ==========================================================
// status fields and serial frame
`define DEA_STAT_ALM2 9
`define DEA_STAT_ALM1 8
`define DEA_FRAME_BITS 5'h10

`endif

/* File: src/dea_alarm_channel.v */
// one alarm channel: static level or averaged slope comparison
`timescale 1ns/1ps
`include "dea_defines.vh"

module dea_alarm_channel (
  clk,
  rst,
  sample_strobe,
  enable,
  slope_mode,
  dir_gt,
  thr_mag,
  averaging_count,
  data,
  event_r
);
  input wire clk;
  input wire rst;
  input wire sample_strobe;
  input wire enable;
  input wire slope_mode;
  input wire dir_gt;
  input wire [13:0] thr_mag;
  input wire [7:0] averaging_count;
  input wire [13:0] data;
  output reg event_r;

  // ========================================================
  // sample history
  // sum of n consecutive deltas telescopes to y(now) - y(now-n),
  // so one ring buffer replaces an accumulator per delta
  reg [13:0] hist_mem [0:255];
  reg [7:0] wp_r;
  reg [7:0] fill_r;
  wire [7:0] n_eff;
  wire [7:0] rd_ptr;
  wire [13:0] y_old;
  wire signed [23:0] delta_sum;
  wire signed [23:0] thr_scaled;
  wire slope_ready;
  reg hit_nxt;

  assign n_eff = (averaging_count == 8'h00) ? 8'h01 : averaging_count;
  assign rd_ptr = wp_r - n_eff;
  assign y_old = hist_mem[rd_ptr];
  assign delta_sum = $signed({10'h000, data}) - $signed({10'h000, y_old}); // see [RULE7]
  // compare sum against thr*n instead of dividing the sum by n
  // operands widened so the product keeps all 22 bits
  assign thr_scaled = $signed({2'h0, ({8'h00, thr_mag} * {14'h0000, n_eff})}); // see [RULE6]
  assign slope_ready = (fill_r >= n_eff);

  // ========================================================
  // comparison
  always @* begin
    hit_nxt = 1'b0;
    if (!slope_mode) begin
      if (dir_gt) begin
        hit_nxt = (data > thr_mag); // see [RULE4]
      end else begin
        hit_nxt = (data < thr_mag);
      end
    end else if (slope_ready) begin
      if (dir_gt) begin
        hit_nxt = (delta_sum > thr_scaled); // see [RULE7]
      end else begin
        hit_nxt = (delta_sum < thr_scaled);
      end
    end
  end

  always @(posedge clk) begin
    if (sample_strobe) begin
      hist_mem[wp_r] <= data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= 8'h00;
      fill_r <= 8'h00;
      event_r <= 1'b0;
    end else if (!enable) begin
      // disabled channel forgets its history and stays quiet
      fill_r <= 8'h00;
      event_r <= 1'b0; // see [RULE18]
    end else if (sample_strobe) begin
      wp_r <= wp_r + 8'h01;
      if (fill_r != 8'hFF) begin
        fill_r <= fill_r + 8'h01;
      end
      event_r <= hit_nxt; // see [RULE3] see [RULE19]
    end
  end
endmodule // dea_alarm_channel

/* File: src/dea_alarm_unit.v */
// dual event alarm unit: serial register slave, two alarm channels, pin drive
// Behaviour
// [RULE1] read-only flash write count at 0x00
// [RULE2] two independent alarm channels
// [RULE3] event when selected data meets comparison
// [RULE4] threshold bit 15 picks greater or less
// [RULE5] threshold bits 13:0 magnitude, bit 14 unused
// [RULE6] sample count bits 7:0 set averaging length
// [RULE7] average sample deltas, compare with magnitude
// [RULE8] config bit 15 alarm 2 slope mode
// [RULE9] config bit 11 alarm 1 slope mode
// [RULE10] bits 14:12 select alarm 2 source
// [RULE11] bits 10:8 select alarm 1 source
// [RULE12] config bit 4 filtered or unfiltered data
// [RULE13] bit2 enable, bit1 polarity, bit0 pin
// [RULE14] alarm 1 threshold kept in nonvolatile storage
// [RULE15] status bits 9 and 8 show alarms
// [RULE16] status read clears latched alarm flags
// [RULE17] gpio beats data-ready beats alarm on pins
// [RULE18] disabled or inactive source never fires
// [RULE19] evaluate once per new sample
`timescale 1ns/1ps
`include "dea_defines.vh"

module dea_alarm_unit (
  clk,
  rst,
  spi_sclk,
  spi_cs_n,
  spi_sdi,
  spi_sdo_r,
  sample_strobe,
  raw_supply,
  raw_gyro,
  raw_aux,
  raw_temp,
  filt_supply,
  filt_gyro,
  filt_aux,
  filt_temp,
  flash_write_done,
  nv_flash_count,
  nv_thr1,
  nv_thr1_r,
  nv_thr1_save_r,
  gpio_dir,
  gpio_level,
  drdy_en,
  drdy_pol,
  drdy_sel,
  drdy_level,
  aux_pin_first_out_r,
  aux_pin_first_oe_n_r,
  aux_pin_second_out_r,
  aux_pin_second_oe_n_r
);
  input wire clk;
  input wire rst;
  input wire spi_sclk;
  input wire spi_cs_n;
  input wire spi_sdi;
  output reg spi_sdo_r;
  input wire sample_strobe;
  input wire [13:0] raw_supply;
  input wire [13:0] raw_gyro;
  input wire [13:0] raw_aux;
  input wire [13:0] raw_temp;
  input wire [13:0] filt_supply;
  input wire [13:0] filt_gyro;
  input wire [13:0] filt_aux;
  input wire [13:0] filt_temp;
  input wire flash_write_done;
  input wire [15:0] nv_flash_count;
  input wire [15:0] nv_thr1;
  output reg [15:0] nv_thr1_r;
  output reg nv_thr1_save_r;
  input wire [1:0] gpio_dir;
  input wire [1:0] gpio_level;
  input wire drdy_en;
  input wire drdy_pol;
  input wire drdy_sel;
  input wire drdy_level;
  output reg aux_pin_first_out_r;
  output reg aux_pin_first_oe_n_r;
  output reg aux_pin_second_out_r;
  output reg aux_pin_second_oe_n_r;

  // ========================================================
  // serial pin synchronisers
  reg [2:0] sclk_sync_r;
  reg [2:0] csn_sync_r;
  reg [2:0] sdi_sync_r;
  reg sclk_f_r;
  reg csn_f_r;
  reg sdi_f_r;
  reg sclk_d_r;
  reg csn_d_r;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_sync_r <= 3'h7;
      csn_sync_r <= 3'h7;
      sdi_sync_r <= 3'h0;
      sclk_f_r <= 1'b1;
      csn_f_r <= 1'b1;
      sdi_f_r <= 1'b0;
      sclk_d_r <= 1'b1;
      csn_d_r <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
      csn_sync_r <= {csn_sync_r[1:0], spi_cs_n};
      sdi_sync_r <= {sdi_sync_r[1:0], spi_sdi};
      // a level counts only once stages two and three agree
      if (sclk_sync_r[1] == sclk_sync_r[2]) begin
        sclk_f_r <= sclk_sync_r[2];
      end
      if (csn_sync_r[1] == csn_sync_r[2]) begin
        csn_f_r <= csn_sync_r[2];
      end
      if (sdi_sync_r[1] == sdi_sync_r[2]) begin
        sdi_f_r <= sdi_sync_r[2];
      end
      sclk_d_r <= sclk_f_r;
      csn_d_r <= csn_f_r;
    end
  end

  assign sclk_rise = sclk_f_r & ~sclk_d_r & ~csn_f_r;
  assign sclk_fall = ~sclk_f_r & sclk_d_r & ~csn_f_r;
  assign cs_fall = ~csn_f_r & csn_d_r;

  // ========================================================
  // registers
  reg [15:0] flash_count_r;
  reg [15:0] thr2_r;
  reg [15:0] smpl1_r;
  reg [15:0] smpl2_r;
  reg [15:0] cfg_r;
  reg [1:0] status_r;
  reg nv_load_r;

  // ========================================================
  // serial frame engine
  reg [4:0] bit_cnt_r;
  reg [15:0] shift_in_r;
  reg [15:0] shift_out_r;
  reg [15:0] rd_word_r;
  reg [15:0] rd_word_nxt;
  wire [15:0] frame_word;
  wire frame_done;
  wire is_write;
  wire [6:0] frame_addr;
  wire [6:0] word_addr;
  wire [7:0] frame_data;
  wire status_read;
  wire [1:0] alarm_ev;

  assign frame_word = {shift_in_r[14:0], sdi_f_r};
  assign frame_done = sclk_rise && (bit_cnt_r == `DEA_FRAME_BITS - 5'h01);
  assign is_write = frame_word[15];
  assign frame_addr = frame_word[14:8];
  assign word_addr = {frame_addr[6:1], 1'b0};
  assign frame_data = frame_word[7:0];
  // read request for status clears it; the word is returned next frame
  assign status_read = frame_done && !is_write && (word_addr == `DEA_ADR_STATUS);

  always @* begin
    case (word_addr)
      `DEA_ADR_FLASH_COUNT: rd_word_nxt = flash_count_r; // see [RULE1]
      `DEA_ADR_THR1: rd_word_nxt = nv_thr1_r & 16'hBFFF; // see [RULE5]
      `DEA_ADR_THR2: rd_word_nxt = thr2_r & 16'hBFFF;
      `DEA_ADR_SMPL1: rd_word_nxt = {8'h00, smpl1_r[7:0]}; // see [RULE6]
      `DEA_ADR_SMPL2: rd_word_nxt = {8'h00, smpl2_r[7:0]};
      `DEA_ADR_CONFIG: rd_word_nxt = cfg_r & 16'hFF17;
      // see [RULE15]
      `DEA_ADR_STATUS: rd_word_nxt = {6'h00, status_r, 8'h00};
      default: rd_word_nxt = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 5'h00;
      shift_in_r <= 16'h0000;
      shift_out_r <= 16'h0000;
      rd_word_r <= 16'h0000;
      spi_sdo_r <= 1'b0;
    end else begin
      if (cs_fall) begin
        bit_cnt_r <= 5'h00;
        shift_out_r <= rd_word_r;
        spi_sdo_r <= rd_word_r[15];
      end else if (sclk_fall && bit_cnt_r != 5'h00) begin
        shift_out_r <= {shift_out_r[14:0], 1'b0};
        spi_sdo_r <= shift_out_r[14];
      end
      if (sclk_rise) begin
        shift_in_r <= frame_word;
        if (frame_done) begin
          bit_cnt_r <= 5'h00;
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
      if (frame_done && !is_write) begin
        rd_word_r <= rd_word_nxt;
      end
    end
  end

  // ========================================================
  // register writes, nonvolatile restore, status
  wire wr_hi;
  wire wr_en;
  assign wr_en = frame_done && is_write;
  assign wr_hi = frame_addr[0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nv_load_r <= 1'b1;
      flash_count_r <= 16'h0000;
      nv_thr1_r <= `DEA_RST_THR;
      nv_thr1_save_r <= 1'b0;
      thr2_r <= `DEA_RST_THR;
      smpl1_r <= `DEA_RST_SMPL;
      smpl2_r <= `DEA_RST_SMPL;
      cfg_r <= `DEA_RST_CONFIG;
      status_r <= `DEA_RST_STATUS;
    end else begin
      nv_load_r <= 1'b0;
      nv_thr1_save_r <= 1'b0;
      if (nv_load_r) begin
        // stored values are taken one cycle after reset release
        flash_count_r <= nv_flash_count; // see [RULE1]
        nv_thr1_r <= nv_thr1; // see [RULE14]
      end else begin
        if (flash_write_done) begin
          flash_count_r <= flash_count_r + 16'h0001; // see [RULE1]
        end
        if (wr_en && word_addr == `DEA_ADR_THR1) begin
          if (wr_hi) begin
            nv_thr1_r[15:8] <= frame_data;
          end else begin
            nv_thr1_r[7:0] <= frame_data;
          end
          nv_thr1_save_r <= 1'b1; // see [RULE14]
        end
      end
      if (wr_en) begin
        case (word_addr)
          `DEA_ADR_THR2: begin
            if (wr_hi) thr2_r[15:8] <= frame_data;
            else thr2_r[7:0] <= frame_data;
          end
          `DEA_ADR_SMPL1: begin
            if (!wr_hi) smpl1_r[7:0] <= frame_data;
          end
          `DEA_ADR_SMPL2: begin
            if (!wr_hi) smpl2_r[7:0] <= frame_data;
          end
          `DEA_ADR_CONFIG: begin
            if (wr_hi) cfg_r[15:8] <= frame_data;
            else cfg_r[7:0] <= frame_data;
          end
          default: begin
          end
        endcase
      end
      // a new event in the clearing cycle survives the clear
      status_r <= (status_r & {2{~status_read}}) | alarm_ev; // see [RULE16] see [RULE15]
    end
  end

  // ========================================================
  // source selection
  function [13:0] pick_src;
    input [2:0] code;
    input filt;
    input [13:0] rs;
    input [13:0] rg;
    input [13:0] ra;
    input [13:0] rt;
    input [13:0] fs;
    input [13:0] fg;
    input [13:0] fa;
    input [13:0] ft;
    begin
      case (code)
        `DEA_SRC_SUPPLY: pick_src = filt ? fs : rs;
        `DEA_SRC_GYRO: pick_src = filt ? fg : rg;
        `DEA_SRC_AUX: pick_src = filt ? fa : ra;
        `DEA_SRC_TEMP: pick_src = filt ? ft : rt;
        default: pick_src = 14'h0000;
      endcase
    end
  endfunction

  function src_valid;
    input [2:0] code;
    begin
      src_valid = (code == `DEA_SRC_SUPPLY) || (code == `DEA_SRC_GYRO) ||
                  (code == `DEA_SRC_AUX) || (code == `DEA_SRC_TEMP);
    end
  endfunction

  wire [2:0] src1;
  wire [2:0] src2;
  wire [13:0] data1;
  wire [13:0] data2;
  assign src1 = cfg_r[`DEA_CFG_SRC1_HI:`DEA_CFG_SRC1_LO]; // see [RULE11]
  assign src2 = cfg_r[`DEA_CFG_SRC2_HI:`DEA_CFG_SRC2_LO]; // see [RULE10]
  assign data1 = pick_src(src1, cfg_r[`DEA_CFG_FILT], raw_supply, raw_gyro, raw_aux,
                          raw_temp, filt_supply, filt_gyro, filt_aux, filt_temp); // see [RULE12]
  assign data2 = pick_src(src2, cfg_r[`DEA_CFG_FILT], raw_supply, raw_gyro, raw_aux,
                          raw_temp, filt_supply, filt_gyro, filt_aux, filt_temp); // see [RULE12]

  // ========================================================
  // alarm channels
  // see [RULE2]
  dea_alarm_channel u_alarm1 (
    .clk(clk),
    .rst(rst),
    .sample_strobe(sample_strobe),
    .enable(src_valid(src1)), // see [RULE18]
    .slope_mode(cfg_r[`DEA_CFG_SLOPE1]), // see [RULE9]
    .dir_gt(nv_thr1_r[`DEA_THR_DIR]),
    .thr_mag(nv_thr1_r[`DEA_THR_MAG_HI:`DEA_THR_MAG_LO]),
    .averaging_count(smpl1_r[`DEA_SMPL_HI:0]),
    .data(data1),
    .event_r(alarm_ev[0])
  );

  dea_alarm_channel u_alarm2 (
    .clk(clk),
    .rst(rst),
    .sample_strobe(sample_strobe),
    .enable(src_valid(src2)), // see [RULE18]
    .slope_mode(cfg_r[`DEA_CFG_SLOPE2]), // see [RULE8]
    .dir_gt(thr2_r[`DEA_THR_DIR]),
    .thr_mag(thr2_r[`DEA_THR_MAG_HI:`DEA_THR_MAG_LO]),
    .averaging_count(smpl2_r[`DEA_SMPL_HI:0]),
    .data(data2),
    .event_r(alarm_ev[1])
  );

  // ========================================================
  // pin arbitration
  wire alarm_any;
  wire alarm_level;
  wire drdy_out;
  reg [1:0] pin_out_nxt;
  reg [1:0] pin_oe_n_nxt;
  integer p;

  assign alarm_any = |alarm_ev;
  assign alarm_level = cfg_r[`DEA_CFG_OUT_POL] ? alarm_any : ~alarm_any; // see [RULE13]
  assign drdy_out = drdy_pol ? drdy_level : ~drdy_level;

  always @* begin
    pin_out_nxt = 2'h0;
    pin_oe_n_nxt = 2'h3;
    for (p = 0; p < 2; p = p + 1) begin
      if (gpio_dir[p]) begin
        pin_out_nxt[p] = gpio_level[p]; // see [RULE17]
        pin_oe_n_nxt[p] = 1'b0;
      end else if (drdy_en && (drdy_sel == p[0])) begin
        pin_out_nxt[p] = drdy_out; // see [RULE17]
        pin_oe_n_nxt[p] = 1'b0;
      end else if (cfg_r[`DEA_CFG_OUT_EN] && (cfg_r[`DEA_CFG_OUT_SEL] == p[0])) begin
        pin_out_nxt[p] = alarm_level; // see [RULE13]
        pin_oe_n_nxt[p] = 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_pin_first_out_r <= 1'b0;
      aux_pin_first_oe_n_r <= 1'b1;
      aux_pin_second_out_r <= 1'b0;
      aux_pin_second_oe_n_r <= 1'b1;
    end else begin
      aux_pin_first_out_r <= pin_out_nxt[0];
      aux_pin_first_oe_n_r <= pin_oe_n_nxt[0];
      aux_pin_second_out_r <= pin_out_nxt[1];
      aux_pin_second_oe_n_r <= pin_oe_n_nxt[1];
    end
  end
endmodule // dea_alarm_unit

/* File: bench/dea_alarm_unit_sva.sv */
// assertions on pin priority and alarm-1 threshold saving
`timescale 1ns/1ps
module dea_alarm_unit_chk (
  input wire clk,
  input wire rst,
  input wire drdy_en,
  input wire drdy_pol,
  input wire drdy_sel,
  input wire drdy_level,
  input wire nv_thr1_save_r,
  input wire [1:0] gpio_dir,
  input wire [1:0] gpio_level,
  input wire [15:0] nv_thr1,
  input wire [15:0] nv_thr1_r,
  input wire aux_pin_first_out_r,
  input wire aux_pin_first_oe_n_r,
  input wire aux_pin_second_out_r,
  input wire aux_pin_second_oe_n_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // pin priority
  a_gpio_first: assert property (
    gpio_dir[0] |=> !aux_pin_first_oe_n_r && aux_pin_first_out_r == $past(gpio_level[0]))
    else $error("first pin not under gpio control");
  a_gpio_second: assert property (
    gpio_dir[1] |=> !aux_pin_second_oe_n_r && aux_pin_second_out_r == $past(gpio_level[1]))
    else $error("second pin not under gpio control");
  a_drdy_first: assert property (
    !gpio_dir[0] && drdy_en && !drdy_sel |=> !aux_pin_first_oe_n_r &&
    aux_pin_first_out_r == ($past(drdy_level) ~^ $past(drdy_pol)))
    else $error("first pin does not show data ready");
  a_drdy_second: assert property (
    !gpio_dir[1] && drdy_en && drdy_sel |=> !aux_pin_second_oe_n_r &&
    aux_pin_second_out_r == ($past(drdy_level) ~^ $past(drdy_pol)))
    else $error("second pin does not show data ready");
  // pins stay released at the first edge after reset
  a_pins_idle: assert property (
    $past(rst) |-> aux_pin_first_oe_n_r && aux_pin_second_oe_n_r)
    else $error("pin driven right after reset");
  // ==========================================
  // stored threshold
  a_thr_capture: assert property (
    $past(rst) |=> nv_thr1_r == $past(nv_thr1))
    else $error("stored threshold not restored");
  a_thr_change: assert property (
    $changed(nv_thr1_r) && !$past(rst, 2) |-> ##[0:1] (nv_thr1_save_r || $past(nv_thr1_save_r)))
    else $error("threshold changed without save pulse");
  a_save_pulse: assert property (
    nv_thr1_save_r |=> !nv_thr1_save_r)
    else $error("save pulse longer than one cycle");
  c_gpio: cover property (gpio_dir == 2'b11);
  c_drdy: cover property (drdy_en && drdy_sel && !gpio_dir[1]);
  c_save: cover property (nv_thr1_save_r);
endmodule // dea_alarm_unit_chk

bind dea_alarm_unit dea_alarm_unit_chk chk_i (.clk, .rst, .drdy_en, .drdy_pol, .drdy_sel,
  .drdy_level, .nv_thr1_save_r, .gpio_dir, .gpio_level, .nv_thr1, .nv_thr1_r,
  .aux_pin_first_out_r, .aux_pin_first_oe_n_r, .aux_pin_second_out_r,
  .aux_pin_second_oe_n_r);

/* File: bench/dea_spi_host.sv */
// serial host model that sends 16-bit frames to the alarm unit
`timescale 1ns/1ps
module dea_spi_host (
  input wire clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire sdo
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // sclk idles high and stands still between frames; sdi is flipped when
  // unused so stale data never looks valid
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    integer k;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (16) @(posedge clk);
    for (k = 15; k >= 0; k--) begin
      sclk <= 1'b0;
      sdi <= w[k];
      repeat (8) @(posedge clk);
      r[k] = sdo;
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (12) @(posedge clk);
  endtask
endmodule // dea_spi_host

/* File: bench/test_dea_alarm_unit.sv */
// self-checking bench for the dual event alarm unit
`timescale 1ns/1ps
`include "dea_defines.vh"
module test_dea_alarm_unit;
  logic clk, rst, sclk, cs_n, sdi, sdo, stb, fwd, drdy_en, drdy_pol, drdy_sel, drdy_level;
  logic [13:0] raw_gyro, filt_gyro, other;
  logic [15:0] nv_cnt, nv_thr, rd;
  logic [1:0] gpio_dir, gpio_level;
  wire p2o, p2e;
  integer fails, tests_run, i;

  dea_spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  dea_alarm_unit dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo_r(sdo), .sample_strobe(stb), .raw_supply(other), .raw_gyro(raw_gyro),
    .raw_aux(other), .raw_temp(other), .filt_supply(other), .filt_gyro(filt_gyro),
    .filt_aux(other), .filt_temp(other), .flash_write_done(fwd), .nv_flash_count(nv_cnt),
    .nv_thr1(nv_thr), .nv_thr1_r(), .nv_thr1_save_r(), .gpio_dir(gpio_dir),
    .gpio_level(gpio_level), .drdy_en(drdy_en), .drdy_pol(drdy_pol), .drdy_sel(drdy_sel),
    .drdy_level(drdy_level), .aux_pin_first_out_r(), .aux_pin_first_oe_n_r(),
    .aux_pin_second_out_r(p2o), .aux_pin_second_oe_n_r(p2e));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // access tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // one byte per frame, low byte first
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer({1'b1, a, d[7:0]}, rd);
    host.xfer({1'b1, a | 7'h01, d[15:8]}, rd);
  endtask
  // the word comes back in the following frame
  task automatic rc(input string n, input logic [6:0] a, input logic [15:0] e);
    host.xfer({1'b0, a, 8'h00}, rd);
    host.xfer(16'h0000, rd);
    chk(n, e, rd);
  endtask
  task automatic strobe;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic ramp(input logic [13:0] b);
    for (i = 0; i < 6; i++) begin
      raw_gyro <= b + 14'(i < 4 ? 10 * i : 30);
      strobe;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    stop_test;
  end
  // ==========================================
  // tests
  initial begin
    rst = 1'b1;
    {stb, fwd, drdy_en, drdy_pol, drdy_sel, drdy_level} = 6'h00;
    {raw_gyro, filt_gyro, other} = 42'h0;
    {gpio_dir, gpio_level} = 4'h0;
    nv_cnt = 16'h0005;
    nv_thr = 16'h8123;
    fails = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rc("flash_write_count", `DEA_ADR_FLASH_COUNT, 16'h0005);
    fwd <= 1'b1;
    @(posedge clk);
    fwd <= 1'b0;
    wr(`DEA_ADR_FLASH_COUNT, 16'h1234);
    rc("flash_write_count", `DEA_ADR_FLASH_COUNT, 16'h0006);
    rc("alarm1_threshold", `DEA_ADR_THR1, 16'h8123);
    for (i = 0; i < 4; i++) begin
      rc("reset_value", `DEA_ADR_THR2 + 7'(2 * i), 16'h0000);
    end
    wr(`DEA_ADR_THR2, 16'hFFFF);
    rc("alarm2_threshold", `DEA_ADR_THR2, 16'hBFFF);
    wr(`DEA_ADR_SMPL2, 16'hFFFF);
    rc("alarm2_sample_count", `DEA_ADR_SMPL2, 16'h00FF);
    wr(`DEA_ADR_CONFIG, 16'hFFFF);
    rc("alarm_config", `DEA_ADR_CONFIG, 16'hFF17);
    // static level, greater than, second pin active high
    wr(`DEA_ADR_THR1, 16'h8100);
    wr(`DEA_ADR_CONFIG, 16'h0207);
    raw_gyro <= 14'h0200;
    strobe;
    chk("second_pin", 16'h0001, {p2e, p2o});
    raw_gyro <= 14'h0000;
    strobe;
    chk("second_pin", 16'h0000, {p2e, p2o});
    rc("status", `DEA_ADR_STATUS, 16'h0100);
    rc("status", `DEA_ADR_STATUS, 16'h0000);
    wr(`DEA_ADR_THR1, 16'h0100);
    raw_gyro <= 14'h0050;
    strobe;
    chk("second_pin", 16'h0001, {p2e, p2o});
    raw_gyro <= 14'h0200;
    strobe;
    chk("second_pin", 16'h0000, {p2e, p2o});
    wr(`DEA_ADR_CONFIG, 16'h0217);
    filt_gyro <= 14'h0050;
    strobe;
    chk("second_pin", 16'h0001, {p2e, p2o});
    filt_gyro <= 14'h0200;
    strobe;
    rc("status", `DEA_ADR_STATUS, 16'h0100);
    // no event now: active low shows 1, then output disabled releases the pin
    wr(`DEA_ADR_CONFIG, 16'h0215);
    chk("second_pin", 16'h0001, {p2e, p2o});
    wr(`DEA_ADR_CONFIG, 16'h0211);
    chk("second_pin", 16'h0002, {p2e, p2o});
    // every alarm 2 source code; only real sources may latch
    wr(`DEA_ADR_THR2, 16'h8000);
    for (i = 0; i < 8; i++) begin
      wr(`DEA_ADR_CONFIG, 16'(i) << 12);
      other <= 14'h0010;
      raw_gyro <= 14'h0010;
      strobe;
      other <= 14'h0000;
      raw_gyro <= 14'h0000;
      strobe;
      rc("status_src", `DEA_ADR_STATUS, 16'((i % 4 == 1 || i % 4 == 2) ? 16'h0200 : 0));
    end
    // drive both pins through gpio and data ready
    for (i = 0; i < 8; i++) begin
      gpio_dir <= i[2:1];
      gpio_level <= i[1:0];
      drdy_en <= 1'b1;
      {drdy_pol, drdy_level, drdy_sel} <= i[2:0];
      repeat (3) @(posedge clk);
    end
    gpio_dir <= 2'b00;
    drdy_en <= 1'b0;
    // slope over two differences: ramp of 10 a sample
    wr(`DEA_ADR_SMPL1, 16'h0002);
    wr(`DEA_ADR_THR1, 16'h8005);
    wr(`DEA_ADR_CONFIG, 16'h0A00);
    ramp(14'h0000);
    rc("status_slope", `DEA_ADR_STATUS, 16'h0100);
    wr(`DEA_ADR_THR1, 16'h8014);
    ramp(14'h001E);
    rc("status_slope", `DEA_ADR_STATUS, 16'h0000);
    stop_test;
  end
endmodule // test_dea_alarm_unit
